// file: verilog/smim_pkg.sv
package smim_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_GENERAL_CONFIG = 8'h03;
  localparam logic [7:0] OFS_RESERVED_BLOCK = 8'h04;
  localparam logic [7:0] OFS_MODE_SELECT_STATUS = 8'h05;
  localparam logic [7:0] OFS_REMOTE_DESER_ADDR = 8'h06;
  localparam logic [7:0] OFS_REMOTE_DESER_ALIAS = 8'h07;
  localparam logic [7:0] OFS_REMOTE_TARGET_ADDR = 8'h08;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_GENERAL_CONFIG = 8'hC5;
  localparam logic [6:0] RST_ADDR7 = 7'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // ==========================================================
  // general_config field positions
  localparam int GEN_FORWARDING_ENABLE = 2;
  localparam int GEN_CLOCK_SOURCE_OVERRIDE = 1;
  localparam int GEN_PIXEL_EDGE_SELECT = 0;
  // ==========================================================
  // mode_select_status field positions
  localparam int MODE_OVERRIDE_BIT = 5;
  localparam int MODE_CURRENT_BIT = 4;
  localparam int MODE_12B_BIT = 3;
  localparam int MODE_10B_BIT = 2;
  // ==========================================================
  // address registers: 7-bit field in 7:1, hold flag in 0 of the deserializer address register only
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int HOLD_BIT = 0;
endpackage : smim_pkg

// file: verilog/smim_remap.sv
// ==========================================================
// alias decode and remap of forwarded two-wire accesses
module smim_remap (
  input wire logic clk, // device clock
  input wire logic arst_n, // async reset, active low
  input wire logic forwarding_enable, // pass-through enable
  input wire logic [6:0] remote_deser_address, // physical deserializer address
  input wire logic [6:0] remote_deser_alias_address, // local alias of deserializer
  input wire logic [6:0] remote_target_address, // physical remote target address
  input wire logic [6:0] remote_target_alias, // local alias of remote target
  input wire logic req_valid, // one-cycle pulse: local access seen
  input wire logic [6:0] req_addr, // 7-bit address of that access
  output logic fwd_valid, // pulse: forward across control channel
  output logic [6:0] fwd_addr, // remapped address for forwarding
  output logic fwd_blocked // pulse: alias hit but path disabled
);
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic blocked;
  } smim_remap_state_t;

  // zero marks an empty address field, so it also closes a path
  localparam logic [6:0] RST_ADDR7_L = smim_pkg::RST_ADDR7;

  smim_remap_state_t state_reg;
  smim_remap_state_t state_next;
  logic des_hit;
  logic tgt_hit;

  // ==========================================================
  // decode; a zero alias never matches so a zero field closes the path
  always_comb begin
    state_next = '0;
    des_hit = req_valid && (remote_deser_alias_address != RST_ADDR7_L) &&
              (req_addr == remote_deser_alias_address); // R12
    tgt_hit = req_valid && (remote_target_alias != RST_ADDR7_L) &&
              (req_addr == remote_target_alias); // R13
    if (des_hit) begin
      if (forwarding_enable && (remote_deser_address != RST_ADDR7_L)) begin // R8 R14
        state_next.valid = 1'b1;
        state_next.addr = remote_deser_address; // R12
      end else begin
        state_next.blocked = 1'b1;
      end
    end else if (tgt_hit) begin
      if (forwarding_enable && (remote_target_address != RST_ADDR7_L)) begin // R13 R14
        state_next.valid = 1'b1;
        state_next.addr = remote_target_address; // R13
      end else begin
        state_next.blocked = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fwd_valid = state_reg.valid;
  assign fwd_addr = state_reg.addr;
  assign fwd_blocked = state_reg.blocked;

  // ==========================================================
  // checks
  AST_FWD_NONZERO: assert property (@(posedge clk) disable iff (!arst_n) // R8
    fwd_valid |-> fwd_addr != RST_ADDR7_L) else $error("forwarded to address zero");
  AST_FWD_DISABLED: assert property (@(posedge clk) disable iff (!arst_n) // R14
    (req_valid && !forwarding_enable) |=> !fwd_valid) else $error("forwarded while off");
  AST_DES_REMAP: assert property (@(posedge clk) disable iff (!arst_n) // R12
    (req_valid && forwarding_enable && remote_deser_alias_address != RST_ADDR7_L &&
     req_addr == remote_deser_alias_address && remote_deser_address != RST_ADDR7_L)
    |=> fwd_valid && fwd_addr == $past(remote_deser_address))
    else $error("alias not remapped to deserializer");
  AST_TGT_BLOCK: assert property (@(posedge clk) disable iff (!arst_n) // R13
    (req_valid && req_addr == remote_target_alias && remote_target_address == RST_ADDR7_L &&
     !(req_addr == remote_deser_alias_address)) |=> !fwd_valid)
    else $error("target access not blocked");
endmodule : smim_remap

// file: verilog/smim_regs.sv
// ==========================================================
// Function
// R1: override set: PLL reference choice comes from the external select, strap ignored.
// R2: override clear (default): PLL reference choice follows the mode strap pin.
// R3: edge select 1 (default) samples rising pixel edge, 0 samples falling.
// R4: mode override bit 5 set ignores back-channel mode bits; clear applies them.
// R5: read-only bit 4 reads 1 when received mode selection is current.
// R6: read-only bit 3 shows 12-bit high-frequency payload mode; resets 0.
// R7: read-only bit 2 shows 10-bit payload mode; resets 0.
// R8: deserializer address in bits 7:1; zero blocks all forwarded deserializer access.
// R9: after receiver lock, deserializer address loads from control-channel information.
// R10: hold bit 0 set keeps written address; clear lets automatic updates proceed.
// R11: host writing its own deserializer address should also set the hold bit.
// R12: accesses matching the deserializer alias remap to its address; zero alias disables.
// R13: remote target alias accesses rewrite to target address; zero address blocks.
// R14: forwarding only while pass-through enable is 1; 0 disables forwarding.
// R15: reserved bits and offset 0x04 read zero; writes to them do nothing.
module smim_regs (
  input wire logic clk, // device clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register offset from local two-wire target
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // one-cycle read strobe
  output logic [7:0] reg_rdata, // read data, valid with reg_rvalid
  output logic reg_rvalid, // one-cycle pulse, read answer
  input wire logic mode_strap_ext_osc, // strap: 1 external oscillator, 0 direct pixel clock
  input wire logic pll_sel_ext_osc, // register-chosen PLL reference (lives elsewhere)
  output logic pll_ref_ext_osc, // selected PLL reference: 1 ext osc
  output logic pixel_edge_rising, // 1 rising edge sampling, 0 falling
  input wire logic rx_lock, // receiver lock level
  input wire logic bc_mode_valid, // pulse: mode bits received on back channel
  input wire logic bc_mode_12b, // received 12-bit high-frequency mode
  input wire logic bc_mode_10b, // received 10-bit mode
  output logic payload_12b, // 12-bit high-frequency payload active
  output logic payload_10b, // 10-bit payload active
  input wire logic bc_id_valid, // pulse: deserializer address received
  input wire logic [6:0] bc_deser_id, // received deserializer address
  input wire logic [6:0] remote_target_alias, // remote target alias, held elsewhere
  input wire logic req_valid, // pulse: local access to forward
  input wire logic [6:0] req_addr, // its 7-bit address
  output logic fwd_valid, // pulse: forward across control channel
  output logic [6:0] fwd_addr, // remapped address
  output logic fwd_blocked // pulse: alias hit but blocked
);
  typedef struct packed {
    logic [7:0] gen;
    logic mode_ovr;
    logic mode_cur;
    logic mode_12b;
    logic mode_10b;
    logic [6:0] des_addr;
    logic des_hold;
    logic [6:0] des_alias;
    logic [6:0] tgt_addr;
    logic pll_ext;
    logic [7:0] rdata;
    logic rvalid;
  } smim_state_t;

  smim_state_t state_reg;
  smim_state_t state_next;
  logic wr_gen;
  logic wr_mode;
  logic wr_des;
  logic wr_alias;
  logic wr_tgt;

  // ==========================================================
  // write decode
  assign wr_gen = reg_wr && (reg_addr == smim_pkg::OFS_GENERAL_CONFIG);
  assign wr_mode = reg_wr && (reg_addr == smim_pkg::OFS_MODE_SELECT_STATUS);
  assign wr_des = reg_wr && (reg_addr == smim_pkg::OFS_REMOTE_DESER_ADDR);
  assign wr_alias = reg_wr && (reg_addr == smim_pkg::OFS_REMOTE_DESER_ALIAS);
  assign wr_tgt = reg_wr && (reg_addr == smim_pkg::OFS_REMOTE_TARGET_ADDR);

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    if (wr_gen) begin
      state_next.gen = reg_wdata;
    end
    // writes to reserved bits and offset 0x04 are simply dropped
    if (wr_mode) begin
      state_next.mode_ovr = reg_wdata[smim_pkg::MODE_OVERRIDE_BIT]; // R15
    end
    // back-channel mode: ignored while overridden, else applied
    if (bc_mode_valid && !state_reg.mode_ovr) begin // R4
      state_next.mode_12b = bc_mode_12b; // R6
      state_next.mode_10b = bc_mode_10b; // R7
      state_next.mode_cur = 1'b1; // R5
    end else if (!rx_lock) begin
      state_next.mode_cur = 1'b0; // lost link makes the copy stale
    end
    // automatic address load; a host write in the same cycle takes priority
    if (rx_lock && bc_id_valid && !state_reg.des_hold) begin // R9 R10
      state_next.des_addr = bc_deser_id;
    end
    if (wr_des) begin // R11
      state_next.des_addr = reg_wdata[smim_pkg::ADDR_MSB:smim_pkg::ADDR_LSB]; // R8
      state_next.des_hold = reg_wdata[smim_pkg::HOLD_BIT]; // R10
    end
    if (wr_alias) begin
      state_next.des_alias = reg_wdata[smim_pkg::ADDR_MSB:smim_pkg::ADDR_LSB]; // R12
    end
    if (wr_tgt) begin
      state_next.tgt_addr = reg_wdata[smim_pkg::ADDR_MSB:smim_pkg::ADDR_LSB]; // R13
    end
    // PLL reference source selection
    if (state_reg.gen[smim_pkg::GEN_CLOCK_SOURCE_OVERRIDE]) begin
      state_next.pll_ext = pll_sel_ext_osc; // R1
    end else begin
      state_next.pll_ext = mode_strap_ext_osc; // R2
    end
    // read mux; unmapped and reserved offsets answer zero
    if (reg_rd) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = smim_pkg::ZERO_BYTE; // R15
      unique case (reg_addr)
        smim_pkg::OFS_GENERAL_CONFIG: begin
          state_next.rdata = state_reg.gen;
        end
        smim_pkg::OFS_MODE_SELECT_STATUS: begin
          state_next.rdata[smim_pkg::MODE_OVERRIDE_BIT] = state_reg.mode_ovr;
          state_next.rdata[smim_pkg::MODE_CURRENT_BIT] = state_reg.mode_cur; // R5
          state_next.rdata[smim_pkg::MODE_12B_BIT] = state_reg.mode_12b; // R6
          state_next.rdata[smim_pkg::MODE_10B_BIT] = state_reg.mode_10b; // R7
        end
        smim_pkg::OFS_REMOTE_DESER_ADDR: begin
          state_next.rdata = {state_reg.des_addr, state_reg.des_hold};
        end
        smim_pkg::OFS_REMOTE_DESER_ALIAS: begin
          state_next.rdata = {state_reg.des_alias, 1'b0};
        end
        smim_pkg::OFS_REMOTE_TARGET_ADDR: begin
          state_next.rdata = {state_reg.tgt_addr, 1'b0};
        end
        default: begin
          state_next.rdata = smim_pkg::ZERO_BYTE;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.gen <= smim_pkg::RST_GENERAL_CONFIG;
      state_reg.des_addr <= smim_pkg::RST_ADDR7;
      state_reg.des_alias <= smim_pkg::RST_ADDR7;
      state_reg.tgt_addr <= smim_pkg::RST_ADDR7;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign pll_ref_ext_osc = state_reg.pll_ext;
  assign pixel_edge_rising = state_reg.gen[smim_pkg::GEN_PIXEL_EDGE_SELECT]; // R3
  assign payload_12b = state_reg.mode_12b;
  assign payload_10b = state_reg.mode_10b;

  // ==========================================================
  // forwarding path
  smim_remap u_remap (
    .clk(clk),
    .arst_n(arst_n),
    .forwarding_enable(state_reg.gen[smim_pkg::GEN_FORWARDING_ENABLE]), // R14
    .remote_deser_address(state_reg.des_addr),
    .remote_deser_alias_address(state_reg.des_alias),
    .remote_target_address(state_reg.tgt_addr),
    .remote_target_alias(remote_target_alias),
    .req_valid(req_valid),
    .req_addr(req_addr),
    .fwd_valid(fwd_valid),
    .fwd_addr(fwd_addr),
    .fwd_blocked(fwd_blocked)
  );

  // ==========================================================
  // checks
  sequence s_write_gen;
    wr_gen;
  endsequence

  sequence s_read_back(logic [7:0] val);
    ##1 reg_rd ##1 (reg_rvalid && reg_rdata == val);
  endsequence

  AST_PLL_OVERRIDE: assert property (@(posedge clk) disable iff (!arst_n) // R1
    state_reg.gen[smim_pkg::GEN_CLOCK_SOURCE_OVERRIDE] |=>
    pll_ref_ext_osc == $past(pll_sel_ext_osc)) else $error("pll reference not from select");
  AST_PLL_STRAP: assert property (@(posedge clk) disable iff (!arst_n) // R2
    !state_reg.gen[smim_pkg::GEN_CLOCK_SOURCE_OVERRIDE] |=>
    pll_ref_ext_osc == $past(mode_strap_ext_osc)) else $error("pll reference not from strap");
  AST_EDGE_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R3
    s_write_gen |=> pixel_edge_rising == $past(reg_wdata[smim_pkg::GEN_PIXEL_EDGE_SELECT]))
    else $error("edge select not applied");
  AST_GEN_READBACK: assert property (@(posedge clk) disable iff (!arst_n) // R14
    (s_write_gen ##1 (reg_rd && reg_addr == smim_pkg::OFS_GENERAL_CONFIG && !reg_wr))
    |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("config readback wrong");
  AST_MODE_IGNORED: assert property (@(posedge clk) disable iff (!arst_n) // R4
    (bc_mode_valid && state_reg.mode_ovr) |=> $stable({payload_12b, payload_10b}))
    else $error("mode changed while overridden");
  AST_MODE_APPLIED: assert property (@(posedge clk) disable iff (!arst_n) // R5
    (bc_mode_valid && !state_reg.mode_ovr) |=>
    state_reg.mode_cur && payload_12b == $past(bc_mode_12b) && payload_10b == $past(bc_mode_10b))
    else $error("mode not applied");
  AST_HOLD_KEEPS: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (state_reg.des_hold && !wr_des) |=> $stable(state_reg.des_addr))
    else $error("held address changed");
  AST_AUTO_LOAD: assert property (@(posedge clk) disable iff (!arst_n) // R9
    (rx_lock && bc_id_valid && !state_reg.des_hold && !wr_des) |=>
    state_reg.des_addr == $past(bc_deser_id)) else $error("address not loaded");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!arst_n) // R15
    (reg_rd && reg_addr == smim_pkg::OFS_RESERVED_BLOCK) |=>
    reg_rvalid && reg_rdata == smim_pkg::ZERO_BYTE)
    else $error("reserved offset not zero");

  // ==========================================================
  // host writes land in their own fields one cycle later
  AST_DES_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R8
    wr_des |=> state_reg.des_addr == $past(reg_wdata[smim_pkg::ADDR_MSB:smim_pkg::ADDR_LSB]) &&
    state_reg.des_hold == $past(reg_wdata[smim_pkg::HOLD_BIT]))
    else $error("address write lost");
  AST_ALIAS_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R12
    wr_alias |=>
    state_reg.des_alias == $past(reg_wdata[smim_pkg::ADDR_MSB:smim_pkg::ADDR_LSB]))
    else $error("alias write lost");
  AST_TGT_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R13
    wr_tgt |=>
    state_reg.tgt_addr == $past(reg_wdata[smim_pkg::ADDR_MSB:smim_pkg::ADDR_LSB]))
    else $error("target write lost");
  AST_MODE_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R4
    wr_mode |=> state_reg.mode_ovr == $past(reg_wdata[smim_pkg::MODE_OVERRIDE_BIT]))
    else $error("mode override write lost");
  // config moves only on a host write; no hidden self-clearing bits here
  AST_GEN_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // R3
    !wr_gen |=> $stable(state_reg.gen))
    else $error("config changed without write");
  // reserved offset swallows writes; config, override, alias and target fields keep their values
  AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R15
    (reg_wr && reg_addr == smim_pkg::OFS_RESERVED_BLOCK) |=>
    $stable({state_reg.gen, state_reg.mode_ovr, state_reg.des_alias, state_reg.tgt_addr}))
    else $error("reserved write took effect");

  // ==========================================================
  // back channel: stale copy after link loss, no load without lock
  AST_MODE_STALE: assert property (@(posedge clk) disable iff (!arst_n) // R5
    (!rx_lock && !bc_mode_valid) |=> !state_reg.mode_cur)
    else $error("stale mode marked current");
  AST_AUTO_REFUSED: assert property (@(posedge clk) disable iff (!arst_n) // R9
    (bc_id_valid && !rx_lock && !wr_des) |=> $stable(state_reg.des_addr))
    else $error("address loaded without lock");

  // ==========================================================
  // read answers carry the stored fields with reserved bits at zero
  AST_GEN_READ: assert property (@(posedge clk) disable iff (!arst_n) // R3
    (reg_rd && reg_addr == smim_pkg::OFS_GENERAL_CONFIG) |=>
    reg_rdata == $past(state_reg.gen))
    else $error("config read wrong");
  AST_MODE_READ: assert property (@(posedge clk) disable iff (!arst_n) // R15
    (reg_rd && reg_addr == smim_pkg::OFS_MODE_SELECT_STATUS) |=> reg_rdata ==
    {2'b00, $past({state_reg.mode_ovr, state_reg.mode_cur, state_reg.mode_12b,
    state_reg.mode_10b}), 2'b00})
    else $error("mode read wrong");
  AST_DES_READ: assert property (@(posedge clk) disable iff (!arst_n) // R8
    (reg_rd && reg_addr == smim_pkg::OFS_REMOTE_DESER_ADDR) |=>
    reg_rdata == $past({state_reg.des_addr, state_reg.des_hold}))
    else $error("address read wrong");
  AST_ALIAS_READ: assert property (@(posedge clk) disable iff (!arst_n) // R12
    (reg_rd && reg_addr == smim_pkg::OFS_REMOTE_DESER_ALIAS) |=>
    reg_rdata == {$past(state_reg.des_alias), 1'b0})
    else $error("alias read wrong");
  AST_TGT_READ: assert property (@(posedge clk) disable iff (!arst_n) // R13
    (reg_rd && reg_addr == smim_pkg::OFS_REMOTE_TARGET_ADDR) |=>
    reg_rdata == {$past(state_reg.tgt_addr), 1'b0})
    else $error("target read wrong");
endmodule : smim_regs

// file: test/smim_far_model.sv
// ==========================================================
// remote end of the control channel: lock level, mode and address frames
module smim_far_model (
  input wire logic clk, // device clock
  output logic rx_lock, // receiver lock level
  output logic bc_mode_valid, // pulse: mode bits present
  output logic bc_mode_12b, // received 12-bit mode bit
  output logic bc_mode_10b, // received 10-bit mode bit
  output logic bc_id_valid, // pulse: address present
  output logic [6:0] bc_deser_id // received deserializer address
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle lines carry the inverse of the last frame so stale data never matches
  initial begin
    rx_lock = 1'b0;
    bc_mode_valid = 1'b0;
    bc_id_valid = 1'b0;
    {bc_mode_12b, bc_mode_10b} = 2'b11;
    bc_deser_id = 7'h7f;
  end
  // lock level changes just after an edge
  task automatic set_lock(input logic lk);
    @(posedge clk);
    #1 rx_lock = lk;
  endtask : set_lock
  // one mode frame; slow adds idle cycles before it
  task automatic send_mode(input logic m12, input logic m10, input int slow);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    #1 {bc_mode_valid, bc_mode_12b, bc_mode_10b} = {1'b1, m12, m10};
    @(posedge clk);
    #1 {bc_mode_valid, bc_mode_12b, bc_mode_10b} = {1'b0, ~m12, ~m10};
  endtask : send_mode
  // one address frame
  task automatic send_id(input logic [6:0] id);
    @(posedge clk);
    #1 {bc_id_valid, bc_deser_id} = {1'b1, id};
    @(posedge clk);
    #1 {bc_id_valid, bc_deser_id} = {1'b0, ~id};
  endtask : send_id
endmodule : smim_far_model

// file: test/testbench.sv
// ==========================================================
// register bank bench: host accesses, back channel, forwarding
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, strap, pll_sel, pll_ref, edge_rise;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic rx_lock, m_valid, m12, m10, p12, p10, id_valid, req_valid, fwd_valid, fwd_blocked;
  logic [6:0] deser_id, target_alias, req_addr, fwd_addr;
  int mismatches = 0;
  int samples_checked = 0;
  smim_regs u_smim_regs (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mode_strap_ext_osc(strap), .pll_sel_ext_osc(pll_sel), .pll_ref_ext_osc(pll_ref),
    .pixel_edge_rising(edge_rise), .rx_lock(rx_lock), .bc_mode_valid(m_valid),
    .bc_mode_12b(m12), .bc_mode_10b(m10), .payload_12b(p12), .payload_10b(p10),
    .bc_id_valid(id_valid), .bc_deser_id(deser_id), .remote_target_alias(target_alias),
    .req_valid(req_valid), .req_addr(req_addr), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .fwd_blocked(fwd_blocked));
  smim_far_model u_smim_far_model (.clk(clk), .rx_lock(rx_lock), .bc_mode_valid(m_valid),
    .bc_mode_12b(m12), .bc_mode_10b(m10), .bc_id_valid(id_valid), .bc_deser_id(deser_id));
  // ==========================================================
  // clock, watchdog and shared tasks
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is about 120 cycles; a hang is cut off well beyond that
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic chk1(input string n, input logic seen, input logic exp);
    check(n, {7'h0, seen}, {7'h0, exp});
  endtask : chk1
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    tick();
    reg_wr = 1'b0;
  endtask : wr
  // answer is a one-cycle pulse, looked at in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    tick();
    reg_rd = 1'b0;
    chk1("reg_rvalid", reg_rvalid, 1'b1);
    check("reg_rdata", reg_rdata, exp);
  endtask : rd
  // write then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    tick();
    {reg_wr, reg_rd} = 2'b01;
    tick();
    reg_rd = 1'b0;
    chk1("reg_rvalid", reg_rvalid, 1'b1);
    check("reg_rdata", reg_rdata, exp);
  endtask : wr_rd
  task automatic fwd(input logic [6:0] a, input logic ev, input logic eb, input logic [6:0] ea);
    @(posedge clk);
    #1 {req_valid, req_addr} = {1'b1, a};
    tick();
    req_valid = 1'b0;
    check("fwd_flags", {6'h0, fwd_valid, fwd_blocked}, {6'h0, ev, eb});
    if (ev) begin
      check("fwd_addr", {1'b0, fwd_addr}, {1'b0, ea});
    end
  endtask : fwd
  // ==========================================================
  // main sequence
  initial begin
    {arst_n, reg_wr, reg_rd, req_valid, pll_sel} = 5'h0;
    {reg_addr, reg_wdata, req_addr} = 23'h0;
    strap = 1'b1;
    target_alias = 7'h50;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    // reset values, reserved and unmapped offsets
    rd(8'h03, 8'hc5);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    chk1("pixel_edge_rising", edge_rise, 1'b1);
    chk1("pll_ref_ext_osc", pll_ref, 1'b1);
    strap = 1'b0;
    tick();
    tick();
    chk1("pll_ref_ext_osc", pll_ref, 1'b0);
    // override: strap ignored, register choice used
    wr(8'h03, 8'hc7);
    pll_sel = 1'b1;
    tick();
    tick();
    chk1("pll_ref_ext_osc", pll_ref, 1'b1);
    wr_rd(8'h03, 8'hc6, 8'hc6);
    chk1("pixel_edge_rising", edge_rise, 1'b0);
    chk1("pll_ref_ext_osc", pll_ref, 1'b1);
    rd(8'h03, 8'hc6);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h00);
    // back-channel mode frames, prompt and slow
    u_smim_far_model.set_lock(1'b1);
    u_smim_far_model.send_mode(1'b1, 1'b0, 0);
    chk1("payload_12b", p12, 1'b1);
    rd(8'h05, 8'h18);
    u_smim_far_model.send_mode(1'b0, 1'b1, 3);
    chk1("payload_10b", p10, 1'b1);
    rd(8'h05, 8'h14);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h34);
    u_smim_far_model.send_mode(1'b1, 1'b0, 0);
    chk1("payload_12b", p12, 1'b0);
    rd(8'h05, 8'h34);
    wr(8'h05, 8'h00);
    u_smim_far_model.send_mode(1'b1, 1'b1, 0);
    rd(8'h05, 8'h1c);
    // automatic address load and the hold bit
    u_smim_far_model.send_id(7'h2a);
    rd(8'h06, 8'h54);
    wr(8'h06, 8'h23);
    u_smim_far_model.send_id(7'h33);
    rd(8'h06, 8'h23);
    wr(8'h06, 8'h22);
    u_smim_far_model.send_id(7'h33);
    rd(8'h06, 8'h66);
    u_smim_far_model.set_lock(1'b0);
    rd(8'h05, 8'h0c);
    u_smim_far_model.send_id(7'h11);
    rd(8'h06, 8'h66);
    // alias decode and remap, one idle cycle between requests
    wr(8'h07, 8'h81);
    rd(8'h07, 8'h80);
    fwd(7'h40, 1'b1, 1'b0, 7'h33);
    fwd(7'h41, 1'b0, 1'b0, 7'h00);
    fwd(7'h50, 1'b0, 1'b1, 7'h00);
    wr(8'h08, 8'h42);
    fwd(7'h50, 1'b1, 1'b0, 7'h21);
    // moved target alias: old address no longer decodes, new one does
    target_alias = 7'h52;
    fwd(7'h50, 1'b0, 1'b0, 7'h00);
    fwd(7'h52, 1'b1, 1'b0, 7'h21);
    wr(8'h03, 8'hc2);
    fwd(7'h40, 1'b0, 1'b1, 7'h00);
    wr(8'h03, 8'hc6);
    wr(8'h06, 8'h01);
    fwd(7'h40, 1'b0, 1'b1, 7'h00);
    wr(8'h07, 8'h00);
    fwd(7'h00, 1'b0, 1'b0, 7'h00);
    close_out();
  end
endmodule : testbench
